// ### design/sar_adc_conversion_control.sv
// How it works
// [RULE1] reset or abort drops converter straight into powered-off idle
// [RULE2] 8-bit short sample: first 18 clocks plus 3 bus, next 16
// [RULE3] 8-bit long sample: first 38 clocks plus 3 bus, next 36
// [RULE4] 10-bit short sample: first 21 clocks plus 3 bus, next 19
// [RULE5] 10-bit long sample: first 41 clocks plus 3 bus, next 39
// [RULE6] converter clock from selected source divided by chosen ratio
// [RULE7] completion flag always set; interrupt only when enabled
// [RULE8] keeps converting in wait; software clears continuous to stay quiet
// [RULE9] single conversion powers down by itself when finished
// [RULE10] stop without alternate clock aborts; results keep last value
// [RULE11] with alternate clock, conversions continue through stop
// [RULE12] alternate clock plus external mode in stop waits for trigger
// [RULE13] in break, flag clears only when break clear enable set
// [RULE14] continuous sample time needs adequate bus to converter clock ratio
// [RULE15] control write starts continuous or one conversion unless channel off
// [RULE16] five-bit channel: 0-5 inputs, 26 bandgap, 29 high, 30 low
// [RULE17] all-ones channel powers off, isolates pad, no extra conversion
// [RULE18] unused channel codes give undefined result
// [RULE19] 10-bit: high byte read freezes results until low byte read
// [RULE20] low power config selects slow reduced-power converter mode
// [RULE21] control write clears flag and aborts before starting anew
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.svh"

module sar_adc_conversion_control
  #(
  parameter int ALT_WAKE_CYCLES = `ALT_WAKE_CYC
  )
  (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ctrl_write,
  input  wire logic                  continuous_select,
  input  wire logic                  conversion_irq_enable,
  input  wire sar_adc_pkg::channel_t channel_field,
  input  wire logic                  ten_bit_mode,
  input  wire logic                  long_sample_select,
  input  wire logic                  input_clock_select,
  input  wire logic                  alt_clock_enable,
  input  wire logic [1:0]            clock_divide_select,
  input  wire logic                  low_power_config,
  input  wire logic                  alt_clock_tick,
  input  wire logic                  external_convert_mode,
  input  wire logic                  external_convert_trigger,
  input  wire logic                  stop_mode,
  input  wire logic                  break_state,
  input  wire logic                  break_clear_enable,
  input  wire logic                  result_high_read,
  input  wire logic                  result_low_read,
  input  wire logic [9:0]            sar_data,
  output logic                       conversion_complete_flag,
  output logic                       conversion_irq,
  output logic [7:0]                 result_high_register,
  output logic [7:0]                 result_low_register,
  output logic                       converter_powered,
  output logic                       pad_isolate,
  output logic                       low_power_mode,
  output logic                       sample_active,
  output sar_adc_pkg::channel_t      mux_select,
  output logic                       channel_undefined
  );
  import sar_adc_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] trig_sync_q;
  logic [1:0] alt_sync_q;
  logic       trig_prev_q;
  logic       alt_prev_q;
  logic       trig_rise;
  logic       alt_rise;

  // two stages for each pin-level input
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      trig_sync_q <= 2'h0;
      alt_sync_q  <= 2'h0;
      trig_prev_q <= 1'b0;
      alt_prev_q  <= 1'b0;
    end
    else
    begin
      trig_sync_q <= {trig_sync_q[0], external_convert_trigger};
      alt_sync_q  <= {alt_sync_q[0], alt_clock_tick};
      trig_prev_q <= trig_sync_q[1];
      alt_prev_q  <= alt_sync_q[1];
    end
  end

  // one-cycle pulses on synchronised rising edges
  assign trig_rise = trig_sync_q[1] & ~trig_prev_q;
  assign alt_rise  = alt_sync_q[1] & ~alt_prev_q;

  // ----------------------------------------
  // converter clock
  // ----------------------------------------
  conv_state_t state_q;
  logic        ck_tick;
  logic        use_alt;
  logic        ck_run;

  // ticks are single bus-cycle pulses, so the converter clock never
  // outruns the bus clock and continuous sample time holds either way
  assign use_alt = input_clock_select & alt_clock_enable;  // see [RULE14]
  assign ck_run  = (state_q == ST_CONV);

  sar_clock_gen i_sar_clock_gen
    (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .run                 (ck_run),
    .alt_tick            (alt_rise),
    .use_alt             (use_alt),
    .clock_divide_select (clock_divide_select),
    .ck_tick             (ck_tick)
    );

  // ----------------------------------------
  // conversion length
  // ----------------------------------------
  logic       first_q;
  logic       cont_q;
  logic [5:0] ck_need;
  logic [5:0] ck_cnt_q;
  logic [1:0] bus_cnt_q;
  logic [15:0] wake_cnt_q;
  logic       ck_done;
  logic       conv_done;
  logic       abort;
  logic       start_req;
  logic       ch_off;

  // clocks per conversion by resolution, sampling and position
  always_comb
  begin
    unique case ({ten_bit_mode, long_sample_select})
      2'b00: ck_need = first_q ? 6'(`CK_8_SHORT_FIRST) : 6'(`CK_8_SHORT_NEXT);  // see [RULE2]
      2'b01: ck_need = first_q ? 6'(`CK_8_LONG_FIRST) : 6'(`CK_8_LONG_NEXT);    // see [RULE3]
      2'b10: ck_need = first_q ? 6'(`CK_10_SHORT_FIRST) : 6'(`CK_10_SHORT_NEXT); // see [RULE4]
      2'b11: ck_need = first_q ? 6'(`CK_10_LONG_FIRST) : 6'(`CK_10_LONG_NEXT);  // see [RULE5]
    endcase
  end

  assign ch_off    = (channel_field == `CH_OFF);
  assign ck_done   = (ck_cnt_q == ck_need);
  // first conversion also pays the bus sync cycles
  assign conv_done = (state_q == ST_CONV) && ck_done
                     && (!first_q || bus_cnt_q == 2'(`BUS_SYNC_CYC));
  // stop without alternate clock or channel off kills the conversion
  assign abort     = (stop_mode && !alt_clock_enable) || ch_off;  // see [RULE10] [RULE17]
  assign start_req = ctrl_write && !ch_off;  // see [RULE15]

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // one conversion at a time, every write with a channel on restarts it
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q    <= ST_OFF;  // see [RULE1]
      first_q    <= 1'b0;
      cont_q     <= 1'b0;
      ck_cnt_q   <= 6'h0;
      bus_cnt_q  <= 2'h0;
      wake_cnt_q <= 16'h0;
    end
    else if (ctrl_write)
    begin
      // a write aborts whatever runs, then restarts unless the channel is off
      cont_q     <= continuous_select;
      first_q    <= 1'b1;
      ck_cnt_q   <= 6'h0;
      bus_cnt_q  <= 2'h0;
      wake_cnt_q <= 16'h0;
      if (!start_req)
        state_q <= ST_OFF;  // see [RULE21]
      else if (external_convert_mode && alt_clock_enable && stop_mode)
        state_q <= ST_TRIG;  // see [RULE12]
      else if (alt_clock_enable)
        state_q <= ST_WAKE;
      else
        state_q <= ST_CONV;  // see [RULE15]
    end
    else if (abort && state_q != ST_OFF)
    begin
      state_q <= ST_OFF;  // see [RULE1] [RULE10]
    end
    else
    begin
      unique case (state_q)
        ST_OFF:
        begin
          ck_cnt_q <= 6'h0;
        end
        ST_TRIG:
        begin
          // idle powered down until the hardware trigger
          if (trig_rise)
            state_q <= ST_WAKE;  // see [RULE12]
        end
        ST_WAKE:
        begin
          // alternate clock startup allowance
          if (wake_cnt_q >= 16'(ALT_WAKE_CYCLES - 1))
            state_q <= ST_CONV;  // see [RULE2]
          else
            wake_cnt_q <= wake_cnt_q + 16'h1;
        end
        ST_CONV:
        begin
          // first conversion also counts the bus sync cycles
          if (first_q && bus_cnt_q != 2'(`BUS_SYNC_CYC))
            bus_cnt_q <= bus_cnt_q + 2'h1;
          if (ck_tick && !ck_done)
            ck_cnt_q <= ck_cnt_q + 6'h1;
          if (conv_done)
          begin
            ck_cnt_q  <= 6'h0;
            bus_cnt_q <= 2'h0;
            first_q   <= 1'b0;
            // wait and stop with alternate clock keep running
            if (!cont_q && external_convert_mode && alt_clock_enable && stop_mode)
              state_q <= ST_TRIG;  // see [RULE12]
            else if (!cont_q)
              state_q <= ST_OFF;  // see [RULE9]
            else
              state_q <= ST_CONV;  // see [RULE8] [RULE11]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // completion flag and interrupt
  // ----------------------------------------
  logic flag_clear_ok;

  // break protects the flag unless clears are allowed
  assign flag_clear_ok = !break_state || break_clear_enable;  // see [RULE13]

  // completion flag and interrupt rise together
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      conversion_complete_flag <= 1'b0;
      conversion_irq           <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      if (conv_done)
        conversion_complete_flag <= 1'b1;  // see [RULE7]
      else if (ctrl_write && flag_clear_ok)
        conversion_complete_flag <= 1'b0;  // see [RULE21] [RULE13]
      // interrupt follows the flag's next value while enabled
      conversion_irq <= conversion_irq_enable
                        && (conv_done || (conversion_complete_flag
                        && !(ctrl_write && flag_clear_ok)));  // see [RULE7]
    end
  end

  // ----------------------------------------
  // result registers with read interlock
  // ----------------------------------------
  logic lock_q;

  // in 10-bit mode a high byte read holds results until the low byte read
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      lock_q <= 1'b0;
    else if (result_low_read)
      lock_q <= 1'b0;  // see [RULE19]
    else if (result_high_read && ten_bit_mode)
      lock_q <= 1'b1;  // see [RULE19]
  end

  // results move only on completion and while unlocked
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      result_high_register <= 8'h00;
      result_low_register  <= 8'h00;
    end
    else if (conv_done && !lock_q)
    begin
      if (ten_bit_mode)
      begin
        result_high_register <= {6'h00, sar_data[9:8]};
        result_low_register  <= sar_data[7:0];
      end
      else
      begin
        result_high_register <= 8'h00;
        result_low_register  <= sar_data[9:2];
      end
    end
  end

  // ----------------------------------------
  // analog front end controls
  // ----------------------------------------
  logic ch_defined;

  // codes with a defined input
  always_comb
  begin
    ch_defined = (channel_field <= `CH_EXT_MAX) || (channel_field == `CH_BANDGAP)
                 || (channel_field == `CH_HIGH_REF)
                 || (channel_field == `CH_LOW_REF);  // see [RULE16]
  end

  // front end controls follow state, channel and the low power config
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      converter_powered <= 1'b0;  // see [RULE1]
      pad_isolate       <= 1'b1;
      low_power_mode    <= 1'b0;
      sample_active     <= 1'b0;
      mux_select        <= `CH_OFF;
      channel_undefined <= 1'b0;
    end
    else
    begin
      converter_powered <= (state_q == ST_CONV) || (state_q == ST_WAKE);
      pad_isolate       <= ch_off;  // see [RULE17]
      low_power_mode    <= low_power_config;  // see [RULE20]
      sample_active     <= (state_q == ST_CONV) && !ck_done;
      mux_select        <= channel_field;  // see [RULE16]
      channel_undefined <= !ch_defined && !ch_off;  // see [RULE18]
    end
  end
endmodule
`default_nettype wire

// ### design/sar_adc_consts.svh
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ----------------------------------------
// timing and encodings
// ----------------------------------------
`define CLK_MHZ            50
`define ALT_WAKE_NS        5000
`define ALT_WAKE_CYC       ((`ALT_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define BUS_SYNC_CYC       3
`define CK_8_SHORT_FIRST   18
`define CK_8_SHORT_NEXT    16
`define CK_8_LONG_FIRST    38
`define CK_8_LONG_NEXT     36
`define CK_10_SHORT_FIRST  21
`define CK_10_SHORT_NEXT   19
`define CK_10_LONG_FIRST   41
`define CK_10_LONG_NEXT    39
`define CH_OFF             5'h1f
`define CH_EXT_MAX         5'h05
`define CH_BANDGAP         5'h1a
`define CH_HIGH_REF        5'h1d
`define CH_LOW_REF         5'h1e
`define LONG_BUS_DIV       11

`endif

// ### design/sar_adc_pkg.sv
package sar_adc_pkg;
  typedef enum logic [3:0] {
    ST_OFF  = 4'b0001,
    ST_WAKE = 4'b0010,
    ST_CONV = 4'b0100,
    ST_TRIG = 4'b1000
  } conv_state_t;
  typedef logic [4:0] channel_t;
endpackage

// ### design/sar_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// converter clock tick generator
// ----------------------------------------
module sar_clock_gen
  (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       alt_tick,
  input  wire logic       use_alt,
  input  wire logic [1:0] clock_divide_select,
  output logic            ck_tick
  );
  logic [2:0] div_cnt_q;
  logic [2:0] div_max;
  logic       src_tick;

  // source pick and ratio 1,2,4,8
  assign src_tick = use_alt ? alt_tick : 1'b1;  // see [RULE6]
  assign div_max  = 3'((4'h1 << clock_divide_select) - 4'h1);

  // divider only runs while the sequencer is in ST_CONV, not during ST_WAKE
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !run)
    begin
      div_cnt_q <= 3'h0;
      ck_tick   <= 1'b0;
    end
    else if (src_tick)
    begin
      ck_tick   <= (div_cnt_q == div_max);  // see [RULE6]
      div_cnt_q <= (div_cnt_q == div_max) ? 3'h0 : div_cnt_q + 3'h1;
    end
    else
    begin
      ck_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/sar_adc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module sar_adc_checker
  (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire logic                  ctrl_write,
  input wire logic                  conversion_irq_enable,
  input wire sar_adc_pkg::channel_t channel_field,
  input wire logic                  alt_clock_enable,
  input wire logic                  low_power_config,
  input wire logic                  stop_mode,
  input wire logic                  break_state,
  input wire logic                  break_clear_enable,
  input wire logic                  conversion_complete_flag,
  input wire logic                  conversion_irq,
  input wire logic                  converter_powered,
  input wire logic                  pad_isolate,
  input wire logic                  low_power_mode,
  input wire sar_adc_pkg::channel_t mux_select,
  input wire logic                  channel_undefined
  );
  import sar_adc_pkg::*;
  logic undef_code;
  // codes with no defined input
  assign undef_code = (channel_field > 5'h05 && channel_field < 5'h1a) ||
                      channel_field == 5'h1b || channel_field == 5'h1c;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // write events
  sequence write_on_s;
    ctrl_write && channel_field != 5'h1f;
  endsequence
  sequence write_off_s;
    ctrl_write && channel_field == 5'h1f;
  endsequence
  sequence flag_en_s;
    (conversion_irq_enable && conversion_complete_flag)[*2];
  endsequence
  irq_on_a: assert property (flag_en_s |-> conversion_irq)
    else $error("irq missing");
  irq_off_a: assert property (!conversion_irq_enable[*2] |-> !conversion_irq)
    else $error("irq while disabled");
  // power output is registered from state, so it drops one cycle after the state
  off_chan_a: assert property (write_off_s |=> pad_isolate ##1 !converter_powered)
    else $error("off code left converter on");
  mux_sel_a: assert property (write_on_s |=> mux_select == $past(channel_field))
    else $error("mux select wrong");
  undef_code_a: assert property (write_on_s |=>
    channel_undefined == $past(undef_code))
    else $error("undefined marker wrong");
  write_clear_a: assert property (ctrl_write && !break_state
    |=> !conversion_complete_flag)
    else $error("write kept flag");
  break_keep_a: assert property (conversion_complete_flag && ctrl_write &&
    break_state && !break_clear_enable |=> conversion_complete_flag)
    else $error("flag cleared in break");
  stop_abort_a: assert property (stop_mode && !alt_clock_enable && !ctrl_write
    |-> ##2 !converter_powered)
    else $error("stop did not abort");
  low_power_a: assert property (!low_power_config[*2] |-> !low_power_mode)
    else $error("low power without config");
endmodule

bind sar_adc_conversion_control sar_adc_checker i_sar_adc_checker (.ref_clk, .sys_rst,
  .ctrl_write, .conversion_irq_enable, .channel_field, .alt_clock_enable, .low_power_config,
  .stop_mode, .break_state, .break_clear_enable, .conversion_complete_flag, .conversion_irq,
  .converter_powered, .pad_isolate, .low_power_mode, .mux_select, .channel_undefined);
`default_nettype wire

// ### tb/sar_adc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_tb;
  import sar_adc_pkg::*;
  logic       ref_clk, sys_rst, ctrl_write, continuous_select, conversion_irq_enable;
  channel_t   channel_field, mux_select;
  logic       ten_bit_mode, long_sample_select, input_clock_select, alt_clock_enable;
  logic [1:0] clock_divide_select;
  logic       low_power_config, alt_clock_tick, external_convert_mode, external_convert_trigger;
  logic       stop_mode, break_state, break_clear_enable, result_high_read, result_low_read;
  logic [9:0] sar_data;
  logic       conversion_complete_flag, conversion_irq, converter_powered, pad_isolate;
  logic       low_power_mode, sample_active, channel_undefined;
  logic [7:0] result_high_register, result_low_register;
  int         fails, n_tests, n;

  sar_adc_conversion_control #(.ALT_WAKE_CYCLES(4)) i_sar_adc_conversion_control (
    .ref_clk, .sys_rst, .ctrl_write, .continuous_select, .conversion_irq_enable,
    .channel_field, .ten_bit_mode, .long_sample_select, .input_clock_select,
    .alt_clock_enable, .clock_divide_select, .low_power_config, .alt_clock_tick,
    .external_convert_mode, .external_convert_trigger, .stop_mode, .break_state,
    .break_clear_enable, .result_high_read, .result_low_read, .sar_data,
    .conversion_complete_flag, .conversion_irq, .result_high_register,
    .result_low_register, .converter_powered, .pad_isolate, .low_power_mode,
    .sample_active, .mux_select, .channel_undefined);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic cont, input channel_t ch);
    @(negedge ref_clk);
    continuous_select = cont;
    channel_field = ch;
    ctrl_write = 1'b1;
    @(negedge ref_clk);
    ctrl_write = 1'b0;
  endtask
  task automatic wait_flag(input int lim);
    n = 0;
    while (conversion_complete_flag !== 1'b1 && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= lim)
    begin
      fails++;
      close_out();
    end
  endtask
  // flag stands after a conversion until the next write, so it is passed in
  task automatic quiet(input int cyc, input logic fl);
    repeat (cyc) @(negedge ref_clk);
    chk({converter_powered, conversion_complete_flag}, {1'b0, fl});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_time(input logic ten, input logic lng, input logic [1:0] dv, input int ck);
    ten_bit_mode = ten;
    long_sample_select = lng;
    clock_divide_select = dv;
    wr(1'b0, 5'h02);
    wait_flag(400);
    chk(16'(n >= ck && n <= ck + 5), 16'h1);
    chk(conversion_irq, 1'b0);
    chk({result_high_register, result_low_register}, ten ? 16'h02b5 : 16'h00ad);
    quiet(3, 1'b1);
  endtask
  task automatic t_cont();
    conversion_irq_enable = 1'b1;
    wr(1'b1, 5'h1a);
    wait_flag(60);
    chk(conversion_irq, 1'b1);
    sar_data = 10'h155;
    n = 0;
    while (result_low_register !== 8'h55 && n < 22)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(result_low_register, 8'h55);
    wr(1'b0, 5'h1f);
    quiet(60, 1'b0);
    chk(pad_isolate, 1'b1);
  endtask
  task automatic t_break();
    break_state = 1'b1;
    wr(1'b0, 5'h00);
    wait_flag(60);
    wr(1'b0, 5'h00);
    chk(conversion_complete_flag, 1'b1);
    break_clear_enable = 1'b1;
    wr(1'b0, 5'h00);
    chk(conversion_complete_flag, 1'b0);
    wait_flag(60);
    break_state = 1'b0;
  endtask
  task automatic t_stop();
    wr(1'b0, 5'h1b);
    repeat (5) @(negedge ref_clk);
    chk(sample_active, 1'b1);
    chk(mux_select, 5'h1b);
    chk(channel_undefined, 1'b1);
    stop_mode = 1'b1;
    quiet(60, 1'b0);
    chk({result_high_register, result_low_register}, 16'h0155);
    stop_mode = 1'b0;
  endtask
  task automatic t_lock();
    result_high_read = 1'b1;
    @(negedge ref_clk);
    result_high_read = 1'b0;
    sar_data = 10'h3c3;
    wr(1'b0, 5'h01);
    wait_flag(60);
    chk({result_high_register, result_low_register}, 16'h0155);
    result_low_read = 1'b1;
    @(negedge ref_clk);
    result_low_read = 1'b0;
    wr(1'b0, 5'h01);
    wait_flag(60);
    chk({result_high_register, result_low_register}, 16'h03c3);
  endtask
  task automatic t_alt();
    {alt_clock_enable, input_clock_select, external_convert_mode, stop_mode} = 4'hf;
    low_power_config = 1'b1;
    wr(1'b0, 5'h04);
    repeat (100) @(negedge ref_clk);
    chk(conversion_complete_flag, 1'b0);
    chk(low_power_mode, 1'b1);
    external_convert_trigger = 1'b1;
    repeat (3) @(negedge ref_clk);
    external_convert_trigger = 1'b0;
    wait_flag(300);
    chk(conversion_irq, 1'b1);
    external_convert_mode = 1'b0;
    wr(1'b0, 5'h05);
    wait_flag(300);
    chk(conversion_irq, 1'b1);
    stop_mode = 1'b0;
  endtask

  // ----------------------------------------
  // clocks and main sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    alt_clock_tick = 1'b0;
    forever #37 alt_clock_tick = ~alt_clock_tick;
  end
  initial
  begin
    fails = 0;
    n_tests = 0;
    {sys_rst, ctrl_write, continuous_select, conversion_irq_enable} = 4'h8;
    {ten_bit_mode, long_sample_select, input_clock_select, alt_clock_enable} = 4'h0;
    {low_power_config, external_convert_mode, external_convert_trigger, stop_mode} = 4'h0;
    {break_state, break_clear_enable, result_high_read, result_low_read} = 4'h0;
    channel_field = 5'h1f;
    clock_divide_select = 2'h0;
    sar_data = 10'h2b5;
    repeat (5) @(negedge ref_clk);
    chk({converter_powered, pad_isolate}, 2'h1);
    chk({conversion_complete_flag, conversion_irq}, 2'h0);
    chk(mux_select, 5'h1f);
    chk({result_high_register, result_low_register}, 16'h0000);
    sys_rst = 1'b0;
    t_time(1'b0, 1'b0, 2'h0, 18);
    t_time(1'b0, 1'b1, 2'h0, 38);
    t_time(1'b1, 1'b0, 2'h0, 21);
    t_time(1'b1, 1'b1, 2'h0, 41);
    t_time(1'b1, 1'b0, 2'h1, 42);
    t_time(1'b1, 1'b0, 2'h3, 168);
    clock_divide_select = 2'h0;
    t_cont();
    t_break();
    t_stop();
    t_lock();
    t_alt();
    close_out();
  end
endmodule
`default_nettype wire
